// ===== src/dpm_pkg.sv
// Package of constants and types for the decoder programming mode block.
package dpm_pkg;

    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned LIT_MS = 1000;
    localparam int unsigned LIT_CYC = CLK_HZ / 1000 * LIT_MS;
    localparam int unsigned TICK_MS = 50;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam logic [6:0] LEGACY_ZERO = 7'h50;
    localparam logic [6:0] SHORT_LIMIT = 7'h50;
    localparam logic [6:0] LONG_KEY = 7'h07;
    localparam logic [13:0] ADDR_RST = 14'h0003;

    typedef enum logic [3:0]
    {
        DPM_PAT_OFF = 4'h0,
        DPM_PAT_BRIEF = 4'h1,
        DPM_PAT_DOUBLE = 4'h2,
        DPM_PAT_STEADY = 4'h3,
        DPM_PAT_SLOW = 4'h4,
        DPM_PAT_LS = 4'h5,
        DPM_PAT_LSS = 4'h6,
        DPM_PAT_LSSS = 4'h7
    } dpm_pat_type;

    // Packet fields as decoded by the track receiver.
    typedef struct packed
    {
        logic valid;
        logic service;
        logic main_write;
        logic verify;
        logic bit_op;
        logic [13:0] addr;
        logic [9:0] cv;
        logic [7:0] data;
        logic [2:0] bit_pos;
        logic bit_val;
    } dpm_cmd_type;

    typedef struct packed
    {
        logic valid;
        logic [9:0] cv;
        logic [7:0] data;
    } dpm_wr_type;

endpackage : dpm_pkg

// ===== src/dpm_flash.sv
// Headlight pattern generator for programming feedback.
`timescale 1ns/100ps
module dpm_flash #(
    parameter int unsigned TICK_CYC = dpm_pkg::TICK_CYC
)
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire dpm_pkg::dpm_pat_type i_pat,
    input wire logic i_restart,
    output logic o_lamp
);

    if (TICK_CYC < 2)
    begin : g_tick_check
        $error("TICK_CYC too small");
    end

    logic [31:0] div_r, div_nxt;
    logic [4:0] step_r, step_nxt;
    logic lamp_r, lamp_nxt;
    logic [15:0] bits_now;

    // Pattern table: 16 ticks per period, one bit per tick.
    function automatic logic [15:0] pat_bits(input dpm_pkg::dpm_pat_type p);
        case (p)
            dpm_pkg::DPM_PAT_BRIEF: pat_bits = 16'h0003;
            dpm_pkg::DPM_PAT_DOUBLE: pat_bits = 16'h0005;
            dpm_pkg::DPM_PAT_STEADY: pat_bits = 16'hFFFF;
            dpm_pkg::DPM_PAT_SLOW: pat_bits = 16'h00FF;
            dpm_pkg::DPM_PAT_LS: pat_bits = 16'h004F;
            dpm_pkg::DPM_PAT_LSS: pat_bits = 16'h014F;
            dpm_pkg::DPM_PAT_LSSS: pat_bits = 16'h054F;
            default: pat_bits = 16'h0000;
        endcase
    endfunction : pat_bits

    always_comb
    begin
        div_nxt = div_r + 32'h1;
        step_nxt = step_r;
        if (div_r >= TICK_CYC - 1)
        begin
            div_nxt = 32'h0;
            step_nxt = step_r + 5'h1;
        end
        // The double flash runs once and then stays dark.
        if (i_pat == dpm_pkg::DPM_PAT_DOUBLE && step_r[4])
        begin
            step_nxt = step_r;
        end
        if (i_restart)
        begin
            div_nxt = 32'h0;
            step_nxt = 5'h0;
        end
        bits_now = pat_bits(i_pat);
        lamp_nxt = bits_now[step_r[3:0]] &
            !(i_pat == dpm_pkg::DPM_PAT_DOUBLE && step_r[4]);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            div_r <= 32'h0;
            step_r <= 5'h0;
            lamp_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            step_r <= step_nxt;
            lamp_r <= lamp_nxt;
        end
    end

    assign o_lamp = lamp_r;

endmodule : dpm_flash

// ===== src/dpm_prog_fsm.sv
// Configuration programming interpreter of the decoder.
`timescale 1ns/100ps
module dpm_prog_fsm #(
    parameter int unsigned LIT_CYC = dpm_pkg::LIT_CYC,
    parameter int unsigned TICK_CYC = dpm_pkg::TICK_CYC
)
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire dpm_pkg::dpm_cmd_type i_cmd,
    input wire logic [13:0] i_my_addr,
    input wire logic i_track_power,
    input wire logic i_dir_change,
    input wire logic [6:0] i_legacy_num,
    input wire logic [7:0] i_cv_rdata,
    output dpm_pkg::dpm_wr_type o_wr,
    output logic o_ack,
    output logic o_lamp,
    output logic o_legacy_active,
    output logic o_long_mode
);

    if (LIT_CYC < 1)
    begin : g_lit_check
        $error("LIT_CYC must be at least one");
    end

    typedef enum logic [7:0]
    {
        DPM_IDLE = 8'h01,
        DPM_ARMED = 8'h02,
        DPM_S_CV = 8'h04,
        DPM_S_VAL = 8'h08,
        DPM_L_CVH = 8'h10,
        DPM_L_CVU = 8'h20,
        DPM_L_VH = 8'h40,
        DPM_L_VU = 8'h80
    } dpm_state_type;

    // Pin inputs pass two flip-flops before use.
    logic pwr_s1_r, pwr_s2_r, pwr_d_r;
    logic dir_s1_r, dir_s2_r, dir_d_r;
    // The keyed number settles well before its confirm edge, so two stages do.
    logic [6:0] num_s1_r, num_s2_r;

    dpm_state_type state_r, state_nxt;
    logic [9:0] cv_r, cv_nxt;
    logic [7:0] val_r, val_nxt;
    logic [31:0] lit_r, lit_nxt;
    dpm_pkg::dpm_pat_type pat_r, pat_nxt;
    logic restart_nxt, restart_r;
    dpm_pkg::dpm_wr_type wr_r, wr_nxt;
    logic ack_r, ack_nxt;
    logic act_r, act_nxt, long_r, long_nxt;

    // A keyed 80 stands for digit pair zero.
    function automatic logic [6:0] digit_pair(input logic [6:0] n);
        digit_pair = (n == dpm_pkg::LEGACY_ZERO) ? 7'h00 : n;
    endfunction : digit_pair

    function automatic logic [9:0] times_ten(input logic [6:0] n);
        times_ten = 10'({3'h0, n} * 10'd10);
    endfunction : times_ten

    logic pwr_up, pwr_dn, dir_ev;
    logic [6:0] num;
    assign pwr_up = pwr_s2_r & !pwr_d_r;
    assign pwr_dn = !pwr_s2_r & pwr_d_r;
    assign dir_ev = dir_s2_r & !dir_d_r;
    assign num = digit_pair(num_s2_r);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            // Powered track is the idle level, so no false edge follows reset.
            pwr_s1_r <= 1'b1;
            pwr_s2_r <= 1'b1;
            pwr_d_r <= 1'b1;
            dir_s1_r <= 1'b0;
            dir_s2_r <= 1'b0;
            dir_d_r <= 1'b0;
            num_s1_r <= 7'h00;
            num_s2_r <= 7'h00;
        end
        else
        begin
            pwr_s1_r <= i_track_power;
            pwr_s2_r <= pwr_s1_r;
            pwr_d_r <= pwr_s2_r;
            dir_s1_r <= i_dir_change;
            dir_s2_r <= dir_s1_r;
            dir_d_r <= dir_s2_r;
            num_s1_r <= i_legacy_num;
            num_s2_r <= num_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    logic addr_hit;
    assign addr_hit = (i_cmd.addr == i_my_addr);

    always_comb
    begin
        state_nxt = state_r;
        cv_nxt = cv_r;
        val_nxt = val_r;
        lit_nxt = (lit_r != 32'h0) ? lit_r - 32'h1 : 32'h0;
        pat_nxt = pat_r;
        restart_nxt = 1'b0;
        wr_nxt = '0;
        ack_nxt = 1'b0;

        // Track-packet writes; readback only on the programming track.
        if (i_cmd.valid && !act_r)
        begin
            if (i_cmd.service || (i_cmd.main_write && addr_hit))
            begin
                if (i_cmd.bit_op)
                begin
                    // Bit 0 is the least significant bit.
                    wr_nxt.data = i_cv_rdata;
                    wr_nxt.data[i_cmd.bit_pos] = i_cmd.bit_val;
                    if (i_cmd.verify)
                    begin
                        ack_nxt = i_cmd.service &
                            (i_cv_rdata[i_cmd.bit_pos] == i_cmd.bit_val);
                    end
                end
                else
                begin
                    wr_nxt.data = i_cmd.data;
                    if (i_cmd.verify)
                    begin
                        ack_nxt = i_cmd.service &
                            (i_cv_rdata == i_cmd.data);
                    end
                end
                wr_nxt.valid = !i_cmd.verify;
                wr_nxt.cv = i_cmd.cv;
            end
        end

        case (state_r)
            DPM_IDLE:
            begin
                // Entry is armed by a direction change while power is off.
                if (dir_ev && !pwr_s2_r)
                begin
                    state_nxt = DPM_ARMED;
                end
            end
            DPM_ARMED:
            begin
                if (pwr_up)
                begin
                    if (num_s2_r[5:0] == i_my_addr[5:0] ||
                        num_s2_r == dpm_pkg::LEGACY_ZERO)
                    begin
                        state_nxt = DPM_S_CV;
                        pat_nxt = dpm_pkg::DPM_PAT_BRIEF;
                        restart_nxt = 1'b1;
                    end
                    else
                    begin
                        state_nxt = DPM_IDLE;
                    end
                end
            end
            DPM_S_CV:
            begin
                if (dir_ev)
                begin
                    if (num == 7'h00)
                    begin
                        state_nxt = DPM_IDLE;
                        pat_nxt = dpm_pkg::DPM_PAT_OFF;
                    end
                    else
                    begin
                        cv_nxt = {3'h0, num};
                        state_nxt = DPM_S_VAL;
                        pat_nxt = dpm_pkg::DPM_PAT_DOUBLE;
                        restart_nxt = 1'b1;
                    end
                end
                else if (lit_r == 32'h1)
                begin
                    pat_nxt = dpm_pkg::DPM_PAT_BRIEF;
                    restart_nxt = 1'b1;
                end
            end
            DPM_S_VAL:
            begin
                if (dir_ev)
                begin
                    if (cv_r < {3'h0, dpm_pkg::SHORT_LIMIT} &&
                        num < dpm_pkg::SHORT_LIMIT)
                    begin
                        wr_nxt.valid = 1'b1;
                        wr_nxt.cv = cv_r;
                        wr_nxt.data = {1'b0, num};
                    end
                    if (cv_r == {3'h0, dpm_pkg::LONG_KEY} &&
                        num == dpm_pkg::LONG_KEY)
                    begin
                        state_nxt = DPM_L_CVH;
                        pat_nxt = dpm_pkg::DPM_PAT_SLOW;
                    end
                    else
                    begin
                        state_nxt = DPM_S_CV;
                        pat_nxt = dpm_pkg::DPM_PAT_STEADY;
                        lit_nxt = LIT_CYC;
                    end
                    restart_nxt = 1'b1;
                end
            end
            DPM_L_CVH:
            begin
                if (dir_ev)
                begin
                    cv_nxt = times_ten(num);
                    state_nxt = DPM_L_CVU;
                    pat_nxt = dpm_pkg::DPM_PAT_LS;
                    restart_nxt = 1'b1;
                end
                else if (lit_r == 32'h1)
                begin
                    pat_nxt = dpm_pkg::DPM_PAT_SLOW;
                    restart_nxt = 1'b1;
                end
            end
            DPM_L_CVU:
            begin
                if (dir_ev)
                begin
                    cv_nxt = cv_r + {3'h0, num};
                    state_nxt = DPM_L_VH;
                    pat_nxt = dpm_pkg::DPM_PAT_LSS;
                    restart_nxt = 1'b1;
                end
            end
            DPM_L_VH:
            begin
                if (dir_ev)
                begin
                    val_nxt = 8'(times_ten(num));
                    state_nxt = DPM_L_VU;
                    pat_nxt = dpm_pkg::DPM_PAT_LSSS;
                    restart_nxt = 1'b1;
                end
            end
            DPM_L_VU:
            begin
                if (dir_ev)
                begin
                    // Any 0..255 result is accepted; larger sums wrap.
                    wr_nxt.valid = 1'b1;
                    wr_nxt.cv = cv_r;
                    wr_nxt.data = val_r + {1'b0, num};
                    state_nxt = DPM_L_CVH;
                    pat_nxt = dpm_pkg::DPM_PAT_STEADY;
                    lit_nxt = LIT_CYC;
                    restart_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = DPM_IDLE;
            end
        endcase

        // Switching track power off ends either legacy mode.
        if (pwr_dn && state_r != DPM_IDLE && state_r != DPM_ARMED)
        begin
            state_nxt = DPM_IDLE;
            pat_nxt = dpm_pkg::DPM_PAT_OFF;
        end
        act_nxt = !(state_nxt == DPM_IDLE || state_nxt == DPM_ARMED);
        long_nxt = state_nxt == DPM_L_CVH || state_nxt == DPM_L_CVU ||
            state_nxt == DPM_L_VH || state_nxt == DPM_L_VU;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_srst)
        begin
            state_r <= DPM_IDLE;
            cv_r <= 10'h000;
            val_r <= 8'h00;
            lit_r <= 32'h0;
            pat_r <= dpm_pkg::DPM_PAT_OFF;
            restart_r <= 1'b0;
            wr_r <= '0;
            ack_r <= 1'b0;
            act_r <= 1'b0;
            long_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cv_r <= cv_nxt;
            val_r <= val_nxt;
            lit_r <= lit_nxt;
            pat_r <= pat_nxt;
            restart_r <= restart_nxt;
            wr_r <= wr_nxt;
            ack_r <= ack_nxt;
            act_r <= act_nxt;
            long_r <= long_nxt;
        end
    end

    dpm_flash #(
        .TICK_CYC(TICK_CYC)
    ) u_flash (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_pat(pat_r),
        .i_restart(restart_r),
        .o_lamp(o_lamp)
    );

    assign o_wr = wr_r;
    assign o_ack = ack_r;
    assign o_legacy_active = act_r;
    assign o_long_mode = long_r;

endmodule : dpm_prog_fsm

// ===== tb/dpm_station.sv
// Command station model driving the decoder track inputs.
`timescale 1ns/100ps
module dpm_station (
    input wire logic i_clk_sys,
    output dpm_pkg::dpm_cmd_type o_cmd,
    output logic o_track_power,
    output logic o_dir_change,
    output logic [6:0] o_legacy_num
);
    initial
    begin
        o_cmd = '0;
        o_track_power = 1'b1;
        o_dir_change = 1'b0;
        o_legacy_num = 7'h01;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : wt

    // Idle fields carry the inverse so nothing relies on stale values.
    task automatic send(input dpm_pkg::dpm_cmd_type c);
        o_cmd = c;
        wt(1);
        c = ~c;
        c.valid = 1'b0;
        o_cmd = c;
    endtask : send

    // Legacy units only key 1 to 80; each key ends with a confirm.
    task automatic key(input logic [6:0] n);
        o_legacy_num = n;
        wt(6);
        o_dir_change = 1'b1;
        wt(6);
        o_dir_change = 1'b0;
        wt(4);
    endtask : key

    task automatic enter(input logic [6:0] n);
        o_track_power = 1'b0;
        wt(6);
        o_dir_change = 1'b1;
        o_legacy_num = n;
        wt(6);
        o_track_power = 1'b1;
        wt(6);
        o_dir_change = 1'b0;
        wt(6);
    endtask : enter

    task automatic cycle_power;
        o_track_power = 1'b0;
        wt(6);
        o_track_power = 1'b1;
        wt(6);
    endtask : cycle_power
endmodule : dpm_station

// ===== tb/dpm_prog_fsm_props.sv
// Concurrent checks on the programming interpreter ports.
`timescale 1ns/100ps
module dpm_prog_fsm_props #(
    parameter int unsigned LIT_CYC = 20
)
(
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire dpm_pkg::dpm_cmd_type i_cmd,
    input wire logic [13:0] i_my_addr,
    input wire logic i_track_power,
    input wire dpm_pkg::dpm_wr_type o_wr,
    input wire logic o_ack,
    input wire logic o_lamp,
    input wire logic o_legacy_active,
    input wire logic o_long_mode
);
    logic [6:0] pwr_r;
    logic [6:0] pwr_nxt;
    logic vfy_r;
    logic vfy_nxt;
    logic pkt_ok;

    assign pkt_ok = i_cmd.valid && !o_legacy_active;

    always_comb
    begin
        pwr_nxt = {pwr_r[5:0], i_track_power};
        vfy_nxt = pkt_ok && i_cmd.service && i_cmd.verify;
        if (i_srst)
        begin
            pwr_nxt = 7'h7F;
            vfy_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        pwr_r <= pwr_nxt;
        vfy_r <= vfy_nxt;
    end

    ////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    a_service_write: assert property (pkt_ok && i_cmd.service &&
        !i_cmd.verify && !i_cmd.bit_op |=> o_wr.valid &&
        o_wr.cv == $past(i_cmd.cv) && o_wr.data == $past(i_cmd.data))
        else $error("service write missing");
    a_main_match: assert property (pkt_ok && i_cmd.main_write &&
        !i_cmd.verify && !i_cmd.bit_op && i_cmd.addr == i_my_addr
        |=> o_wr.valid && o_wr.data == $past(i_cmd.data))
        else $error("main write missing");
    a_main_skip: assert property (pkt_ok && i_cmd.main_write &&
        !i_cmd.service && i_cmd.addr != i_my_addr |=> !o_wr.valid)
        else $error("foreign main write done");
    a_main_noack: assert property (pkt_ok && i_cmd.main_write &&
        !i_cmd.service |=> !o_ack)
        else $error("main verify answered");
    a_ack_cause: assert property (o_ack |-> vfy_r)
        else $error("ack without service verify");
    a_short_range: assert property (o_wr.valid && o_legacy_active &&
        !o_long_mode |-> o_wr.cv < 10'h050 && o_wr.data < 8'h50)
        else $error("short write out of range");
    a_long_steady: assert property (o_wr.valid && o_long_mode
        |-> ##[1:3] o_lamp [*8])
        else $error("lamp not steady after write");
    a_long_inside: assert property (o_long_mode |-> o_legacy_active)
        else $error("long mode outside legacy");
    a_long_exit: assert property ($fell(o_long_mode) |->
        pwr_r != 7'h7F)
        else $error("long mode left without power loss");
endmodule : dpm_prog_fsm_props

bind dpm_prog_fsm dpm_prog_fsm_props #(.LIT_CYC(LIT_CYC)) i_props (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_cmd(i_cmd),
    .i_my_addr(i_my_addr),
    .i_track_power(i_track_power),
    .o_wr(o_wr),
    .o_ack(o_ack),
    .o_lamp(o_lamp),
    .o_legacy_active(o_legacy_active),
    .o_long_mode(o_long_mode)
);

// ===== tb/dpm_prog_fsm_tb.sv
// Self-checking testbench of the programming interpreter.
`timescale 1ns/100ps
module dpm_prog_fsm_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [13:0] my_addr = 14'h0003;
    logic [7:0] cv_rdata = 8'h00;
    dpm_pkg::dpm_cmd_type cmd;
    dpm_pkg::dpm_wr_type wr;
    dpm_pkg::dpm_wr_type wr_last;
    logic power, dir, ack, lamp, legacy_active, long_mode;
    logic [6:0] num;
    int err_count = 0;
    int cmp_count = 0;
    int wr_n = 0;
    int ack_n = 0;

    always #2 clk_sys = ~clk_sys;

    dpm_station i_dpm_station (.i_clk_sys(clk_sys), .o_cmd(cmd),
        .o_track_power(power), .o_dir_change(dir), .o_legacy_num(num));

    // Short counts keep the one second lamp within a brief run.
    dpm_prog_fsm #(.LIT_CYC(20), .TICK_CYC(4)) i_dpm_prog_fsm (
        .i_clk_sys(clk_sys), .i_srst(srst), .i_cmd(cmd),
        .i_my_addr(my_addr), .i_track_power(power),
        .i_dir_change(dir), .i_legacy_num(num), .i_cv_rdata(cv_rdata),
        .o_wr(wr), .o_ack(ack), .o_lamp(lamp),
        .o_legacy_active(legacy_active), .o_long_mode(long_mode));

    always @(posedge clk_sys)
    begin
        if (wr.valid === 1'b1)
        begin
            wr_n++;
            wr_last = wr;
        end
        if (ack === 1'b1)
            ack_n++;
    end

    ////////////////////////////////////////
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wt

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_wr(input int n0, input logic [17:0] exp);
        chk(wr_n - n0, 32'h1);
        chk({wr_last.cv, wr_last.data}, {14'h0, exp});
    endtask : chk_wr

    // Flags are service, main write, verify, bit operation.
    task automatic pkt(input logic [3:0] f, input logic [13:0] a,
        input logic [9:0] cv, input logic [7:0] d, input logic [3:0] b);
        i_dpm_station.send({1'b1, f, a, cv, d, b});
        wt(2);
    endtask : pkt

    // Lit cycles over one 64-cycle flash period.
    task automatic lamp_on(output int n);
        n = 0;
        repeat (64)
        begin
            wt(1);
            if (lamp === 1'b1)
                n++;
        end
    endtask : lamp_on

    task automatic t_service;
        int n0;
        n0 = wr_n;
        cv_rdata = 8'h5A;
        pkt(4'h8, 14'h1234, 10'h01F, 8'h07, 4'h0);
        chk_wr(n0, {10'h01F, 8'h07});
        n0 = ack_n;
        pkt(4'hA, 14'h1234, 10'h01F, 8'h5A, 4'h0);
        chk(ack_n - n0, 32'h1);
        n0 = wr_n;
        cv_rdata = 8'h00;
        pkt(4'h9, 14'h1234, 10'h01F, 8'h00, 4'hF);
        chk_wr(n0, {10'h01F, 8'h80});
        n0 = wr_n;
        cv_rdata = 8'hFF;
        pkt(4'h9, 14'h1234, 10'h01F, 8'hFF, 4'h0);
        chk_wr(n0, {10'h01F, 8'hFE});
    endtask : t_service

    // A wide address makes the upper address bits take part in the match.
    task automatic t_main;
        int n0;
        my_addr = 14'h2A5C;
        n0 = wr_n;
        pkt(4'h4, 14'h2A5C, 10'h020, 8'h33, 4'h0);
        chk_wr(n0, {10'h020, 8'h33});
        n0 = wr_n;
        pkt(4'h4, 14'h0A5C, 10'h020, 8'h44, 4'h0);
        chk(wr_n - n0, 32'h0);
        n0 = ack_n;
        cv_rdata = 8'h33;
        pkt(4'h6, 14'h2A5C, 10'h020, 8'h33, 4'h0);
        chk(ack_n - n0, 32'h0);
    endtask : t_main

    task automatic t_short;
        int n0;
        int n;
        logic l0;
        i_dpm_station.enter(7'h50);
        chk({legacy_active, long_mode}, 32'h2);
        n = 0;
        repeat (70)
        begin
            l0 = lamp;
            wt(1);
            if (lamp !== l0)
                n++;
        end
        chk(n != 0, 32'h1);
        n0 = wr_n;
        i_dpm_station.key(7'h0F);
        lamp_on(n);
        chk(n != 0, 32'h1);
        lamp_on(n);
        chk(n, 32'h0);
        i_dpm_station.key(7'h16);
        chk_wr(n0, {10'h00F, 8'h16});
        chk(lamp, 32'h1);
        wt(24);
        n0 = wr_n;
        pkt(4'h8, 14'h2A5C, 10'h030, 8'h01, 4'h0);
        chk(wr_n - n0, 32'h0);
        i_dpm_station.key(7'h05);
        i_dpm_station.key(7'h50);
        chk_wr(n0, {10'h005, 8'h00});
        wt(24);
        i_dpm_station.key(7'h50);
        chk(legacy_active, 32'h0);
    endtask : t_short

    task automatic t_long;
        int n0;
        int n_ls;
        int n_lss;
        int n_lsss;
        i_dpm_station.enter(7'h1C);
        chk(legacy_active, 32'h1);
        i_dpm_station.key(7'h07);
        i_dpm_station.key(7'h07);
        wt(24);
        chk(long_mode, 32'h1);
        lamp_on(n0);
        chk(n0 > 0 && n0 < 64, 32'h1);
        n0 = wr_n;
        i_dpm_station.key(7'h0C);
        lamp_on(n_ls);
        i_dpm_station.key(7'h04);
        lamp_on(n_lss);
        i_dpm_station.key(7'h0D);
        lamp_on(n_lsss);
        i_dpm_station.key(7'h05);
        chk_wr(n0, {10'h07C, 8'h87});
        chk(n_ls > 0 && n_ls < n_lss, 32'h1);
        chk(n_lss < n_lsss, 32'h1);
        wt(24);
        n0 = wr_n;
        i_dpm_station.key(7'h19);
        i_dpm_station.key(7'h05);
        i_dpm_station.key(7'h19);
        i_dpm_station.key(7'h05);
        chk_wr(n0, {10'h0FF, 8'hFF});
        wt(24);
        i_dpm_station.key(7'h50);
        chk(long_mode, 32'h1);
        i_dpm_station.cycle_power();
        chk({legacy_active, long_mode}, 32'h0);
        i_dpm_station.enter(7'h50);
        i_dpm_station.cycle_power();
        chk(legacy_active, 32'h0);
        i_dpm_station.enter(7'h05);
        chk(legacy_active, 32'h0);
    endtask : t_long

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        wrap_up();
    end

    initial
    begin
        wt(16);
        srst = 1'b0;
        t_service();
        t_main();
        t_short();
        t_long();
        wrap_up();
    end
endmodule : dpm_prog_fsm_tb
